// ===== hw/pmc_power_ctrl.sv
// Power modes, wake logic and system clock control behind an APB slave
`timescale 1ns/1ps
module pmc_power_ctrl
   import pmc_pkg::*;
#(
   parameter int unsigned MCD_TIMEOUT_CYCLES = PMC_MCD_CYCLES,
   parameter int unsigned RST_SEQ_CYCLES = PMC_RST_SEQ_CYCLES,
   parameter int unsigned OSC_START_CYCLES = PMC_OSC_START_CYCLES,
   parameter int unsigned TRIM_W = PMC_TRIM_W
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PMC_ADDR_W-1:0] paddr,
   input wire logic [PMC_DATA_W-1:0] pwdata,
   output logic [PMC_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire pmc_wake_s wake,
   input wire logic extRst,
   input wire logic intRstReq,
   input wire logic [TRIM_W-1:0] factoryCoarse,
   input wire logic [TRIM_W-1:0] factoryFine,
   output pmc_clk_s clkCtl,
   output logic [TRIM_W-1:0] coarseTrim,
   output logic [TRIM_W-1:0] fineTrim,
   output logic coreRst,
   output logic [15:0] resetVector,
   output logic irq
);
   pmc_state_e state_q;
   pmc_state_e state_d;
   logic [PMC_CNT_W-1:0] seqCnt_q;
   logic [PMC_CNT_W-1:0] mcdCnt_q;
   logic stopSel_q;
   logic suspend_q;
   logic [PMC_DIV_W-1:0] divSel_q;
   logic [TRIM_W-1:0] coarse_q;
   logic [TRIM_W-1:0] fine_q;
   logic mcdEn_q;
   logic [PMC_IRQ_W-1:0] status_q;
   logic [PMC_IRQ_W-1:0] status_d;
   logic [PMC_IRQ_W-1:0] statusSet;
   logic [PMC_IRQ_W-1:0] statusClr;
   logic [PMC_IRQ_W-1:0] mask_q;
   logic [PMC_RSRC_W-1:0] rsrc_q;
   logic [PMC_RSRC_W-1:0] rsrcNow;
   logic [PMC_DATA_W-1:0] prdata_q;
   logic [PMC_DATA_W-1:0] rdWord;
   logic rdHit;
   logic err_q;
   logic rdStat_q;
   logic apbSetup;
   logic apbAccess;
   logic cpuLive;
   logic wrEn;
   logic rdEn;
   logic seqRst;
   logic portWake;
   logic cmpWake;
   logic anyWake;
   logic mcdFire;
   logic anyRst;
   logic seqDone;
   logic oscStartDone;
   logic oscOn;
   logic divTick;
   pmc_clk_s clk_q;
   logic irq_q;
   logic coreRst_q;

   // APB phases; slave answers in the first access cycle with data from a flop
   assign apbSetup = psel && !penable;
   assign apbAccess = psel && penable;
   assign pready = apbAccess;
   assign prdata = prdata_q;
   assign pslverr = apbAccess && err_q;
   // The CPU is the only writer, so writes count only while it executes
   assign cpuLive = (state_q == PMC_ST_RUN);
   assign wrEn = apbAccess && pwrite && !err_q && cpuLive;
   assign rdEn = apbAccess && !pwrite && !err_q;

   // Wake detection is pure logic on the pins, no oscillator clock needed
   assign portWake = |wake.portMatch;
   assign cmpWake = wake.cmp0En && !wake.cmp0Out;
   assign anyWake = portWake || cmpWake;

   assign mcdFire = mcdEn_q && (state_q == PMC_ST_STOP)
      && (mcdCnt_q == PMC_CNT_W'(MCD_TIMEOUT_CYCLES - 1));
   assign rsrcNow[PMC_RSRC_EXT] = extRst;
   assign rsrcNow[PMC_RSRC_INT] = intRstReq;
   assign rsrcNow[PMC_RSRC_MCD] = mcdFire;
   assign anyRst = |rsrcNow;
   // Reset sequence reloads every control register, like a power-up
   assign seqRst = sys_rst || (state_q == PMC_ST_RESET);
   assign seqDone = (seqCnt_q == PMC_CNT_W'(RST_SEQ_CYCLES - 1));
   assign oscStartDone = (seqCnt_q == PMC_CNT_W'(OSC_START_CYCLES - 1));

   // Read decode, captured in the setup cycle
   always_comb begin
      rdWord = PMC_ZERO_WORD;
      rdHit = 1'b1;
      unique case (paddr)
         PMC_OFS_PWR: begin
            rdWord[PMC_PWR_STOP_BIT] = stopSel_q;
         end
         PMC_OFS_OSC: begin
            rdWord[PMC_OSC_DIV_LSB +: PMC_DIV_W] = divSel_q;
            rdWord[PMC_OSC_SUSPEND_BIT] = suspend_q;
            rdWord[PMC_OSC_READY_BIT] = oscOn && (state_q != PMC_ST_WAKE);
         end
         PMC_OFS_COARSE: begin
            rdWord[TRIM_W-1:0] = coarse_q;
         end
         PMC_OFS_FINE: begin
            rdWord[TRIM_W-1:0] = fine_q;
         end
         PMC_OFS_MCD: begin
            rdWord[PMC_MCD_EN_BIT] = mcdEn_q;
         end
         PMC_OFS_ISTAT: begin
            rdWord[PMC_IRQ_W-1:0] = status_q;
         end
         PMC_OFS_IMASK: begin
            rdWord[PMC_IRQ_W-1:0] = mask_q;
         end
         PMC_OFS_MODE: begin
            rdWord[PMC_MODE_STATE_LSB +: 3] = state_q;
            rdWord[PMC_MODE_RSRC_LSB +: PMC_RSRC_W] = rsrc_q;
         end
         default: begin
            rdHit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prdata_q <= PMC_ZERO_WORD;
         err_q <= 1'b0;
         rdStat_q <= 1'b0;
      end else if (apbSetup) begin
         prdata_q <= rdWord;
         err_q <= !rdHit;
         rdStat_q <= (paddr == PMC_OFS_ISTAT);
      end
   end

   // Stop select: set by the write, left only through a reset
   always_ff @(posedge clk) begin
      if (seqRst) begin
         stopSel_q <= 1'b0;
      end else if (wrEn && paddr == PMC_OFS_PWR && pwdata[PMC_PWR_STOP_BIT]) begin
         stopSel_q <= 1'b1;
      end
   end

   // Suspend bit self-clears when the wake completes
   always_ff @(posedge clk) begin
      if (seqRst) begin
         suspend_q <= 1'b0;
      end else if (state_q == PMC_ST_WAKE && oscStartDone) begin
         suspend_q <= 1'b0;
      end else if (wrEn && paddr == PMC_OFS_OSC && pwdata[PMC_OSC_SUSPEND_BIT]) begin
         suspend_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (seqRst) begin
         divSel_q <= PMC_DIV_RESET;
      end else if (wrEn && paddr == PMC_OFS_OSC) begin
         divSel_q <= pwdata[PMC_OSC_DIV_LSB +: PMC_DIV_W];
      end
   end

   // Trim values reloaded from the factory inputs on every reset sequence
   always_ff @(posedge clk) begin
      if (seqRst) begin
         coarse_q <= factoryCoarse;
         fine_q <= factoryFine;
      end else if (wrEn && paddr == PMC_OFS_COARSE) begin
         coarse_q <= pwdata[TRIM_W-1:0];
      end else if (wrEn && paddr == PMC_OFS_FINE) begin
         fine_q <= pwdata[TRIM_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (seqRst) begin
         mcdEn_q <= PMC_MCD_EN_RESET;
         mask_q <= PMC_IMASK_RESET;
      end else if (wrEn && paddr == PMC_OFS_MCD) begin
         mcdEn_q <= pwdata[PMC_MCD_EN_BIT];
      end else if (wrEn && paddr == PMC_OFS_IMASK) begin
         mask_q <= pwdata[PMC_IRQ_W-1:0];
      end
   end

   // Sticky wake events; a read clears only what it returned, sets win
   always_comb begin
      statusSet = '0;
      if (state_q == PMC_ST_SUSPEND) begin
         statusSet[PMC_IRQ_PORT] = portWake;
         statusSet[PMC_IRQ_CMP] = cmpWake;
      end
      statusSet[PMC_IRQ_OSCRDY] = (state_q == PMC_ST_WAKE) && oscStartDone;
      statusClr = '0;
      if (rdEn && rdStat_q) begin
         statusClr = prdata_q[PMC_IRQ_W-1:0];
      end
      status_d = (status_q & ~statusClr) | statusSet;
   end

   always_ff @(posedge clk) begin
      if (seqRst) begin
         status_q <= '0;
      end else begin
         status_q <= status_d;
      end
   end

   // Cause of the last reset sequence survives the sequence itself
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rsrc_q <= '0;
      end else if (anyRst && state_q != PMC_ST_RESET) begin
         rsrc_q <= rsrcNow;
      end
   end

   // Mode sequencer
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         PMC_ST_RESET: begin
            if (anyRst) begin
               state_d = PMC_ST_RESET;
            end else if (seqDone) begin
               state_d = PMC_ST_RUN;
            end
         end
         PMC_ST_RUN: begin
            if (anyRst) begin
               state_d = PMC_ST_RESET;
            end else if (stopSel_q) begin
               state_d = PMC_ST_STOP;
            end else if (suspend_q) begin
               state_d = PMC_ST_SUSPEND;
            end
         end
         PMC_ST_SUSPEND: begin
            if (anyRst) begin
               state_d = PMC_ST_RESET;
            end else if (anyWake) begin
               state_d = PMC_ST_WAKE;
            end
         end
         PMC_ST_WAKE: begin
            if (anyRst) begin
               state_d = PMC_ST_RESET;
            end else if (oscStartDone) begin
               state_d = PMC_ST_RUN;
            end
         end
         PMC_ST_STOP: begin
            // Wake pins are ignored here on purpose
            if (anyRst) begin
               state_d = PMC_ST_RESET;
            end
         end
         default: begin
            state_d = PMC_ST_RESET;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= PMC_ST_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   // Shared counter for reset length and oscillator start-up
   always_ff @(posedge clk) begin
      if (sys_rst || state_d != state_q) begin
         seqCnt_q <= '0;
      end else if (state_q == PMC_ST_RESET && anyRst) begin
         seqCnt_q <= '0;
      end else if (state_q == PMC_ST_RESET || state_q == PMC_ST_WAKE) begin
         seqCnt_q <= seqCnt_q + PMC_CNT_W'(1);
      end
   end

   // Detector counts missing oscillator edges while stopped
   always_ff @(posedge clk) begin
      if (sys_rst || state_q != PMC_ST_STOP || !mcdEn_q) begin
         mcdCnt_q <= '0;
      end else if (!mcdFire) begin
         mcdCnt_q <= mcdCnt_q + PMC_CNT_W'(1);
      end
   end

   // Oscillator restarts in the wake state, ahead of the CPU clock
   assign oscOn = (state_q == PMC_ST_RESET) || (state_q == PMC_ST_RUN)
      || (state_q == PMC_ST_WAKE);

   pmc_clk_div #(
      .DIV_W(PMC_DIV_W),
      .PRE_W(PMC_PRE_W)
   ) uDiv (
      .clk(clk),
      .sys_rst(sys_rst),
      .run(oscOn),
      .divSel(divSel_q),
      .tick(divTick)
   );

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         clk_q <= '0;
      end else begin
         clk_q.oscRun <= oscOn;
         clk_q.sysClkEn <= divTick && oscOn;
         // CPU clock held back in Stop, Suspend and oscillator start-up
         clk_q.cpuClkEn <= divTick && (state_q == PMC_ST_RUN || state_q == PMC_ST_RESET);
         clk_q.periphClkEn <= divTick && (state_q == PMC_ST_RUN || state_q == PMC_ST_RESET);
         clk_q.portMatchEn <= (state_q != PMC_ST_STOP);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_q <= 1'b0;
         coreRst_q <= 1'b1;
      end else begin
         irq_q <= |(status_d & mask_q);
         coreRst_q <= (state_d == PMC_ST_RESET);
      end
   end

   assign clkCtl = clk_q;
   assign coarseTrim = coarse_q;
   assign fineTrim = fine_q;
   assign coreRst = coreRst_q;
   assign resetVector = PMC_RESET_VECTOR;
   assign irq = irq_q;
endmodule

// ===== hw/pmc_pkg.sv
// Constants, types and register map of the power-mode and clock controller
// Behaviour
// - Writing the stop select bit enters Stop once that write completes.
// - Stop halts internal oscillator, CPU and all digital peripherals; external oscillator untouched.
// - Only a reset ends Stop; then normal reset sequence, fetch from address zero.
// - Enabled missing clock detector resets out of Stop; disable it for long stops.
// - Writing the suspend bit halts CPU and internal oscillator after that write.
// - Suspend keeps all registers and memory; only port-match logic stays active.
// - Suspend ends on port 0-3 match, enabled comparator 0 low, or reset.
// - Non-reset wake resumes oscillator, CPU, peripherals; execution continues after the write.
// - A wake source set to interrupt is serviced right after waking.
// - A reset during Suspend runs the reset sequence and starts at address zero.
// - After any reset the internal oscillator, trimmed to 24 MHz, is system clock.
// - System clock is oscillator divided by 1 to 128; reset division is 128.
// - Coarse and fine trim registers adjust the oscillator, reset to factory values.
// - Suspending the oscillator stops CPU and peripheral clocks until a wake event.
package pmc_pkg;
   localparam int unsigned PMC_CLK_MHZ = 125;
   localparam int unsigned PMC_OSC_BASE_MHZ = 24;
   localparam int unsigned PMC_MCD_TIMEOUT_US = 100;
   localparam int unsigned PMC_MCD_CYCLES = PMC_MCD_TIMEOUT_US * PMC_CLK_MHZ;
   localparam int unsigned PMC_OSC_START_NS = 200;
   localparam int unsigned PMC_OSC_START_CYCLES = (PMC_OSC_START_NS * PMC_CLK_MHZ + 999) / 1000;
   localparam int unsigned PMC_RST_SEQ_NS = 128;
   localparam int unsigned PMC_RST_SEQ_CYCLES = (PMC_RST_SEQ_NS * PMC_CLK_MHZ + 999) / 1000;
   localparam int unsigned PMC_CNT_W = 24;
   localparam int unsigned PMC_ADDR_W = 8;
   localparam int unsigned PMC_DATA_W = 32;
   localparam int unsigned PMC_TRIM_W = 8;
   localparam int unsigned PMC_DIV_W = 3;
   localparam int unsigned PMC_PRE_W = 7;
   localparam int unsigned PMC_IRQ_W = 3;
   localparam int unsigned PMC_RSRC_W = 3;
   localparam logic [PMC_ADDR_W-1:0] PMC_OFS_PWR = 8'h00;
   localparam logic [PMC_ADDR_W-1:0] PMC_OFS_OSC = 8'h04;
   localparam logic [PMC_ADDR_W-1:0] PMC_OFS_COARSE = 8'h08;
   localparam logic [PMC_ADDR_W-1:0] PMC_OFS_FINE = 8'h0C;
   localparam logic [PMC_ADDR_W-1:0] PMC_OFS_MCD = 8'h10;
   localparam logic [PMC_ADDR_W-1:0] PMC_OFS_ISTAT = 8'h14;
   localparam logic [PMC_ADDR_W-1:0] PMC_OFS_IMASK = 8'h18;
   localparam logic [PMC_ADDR_W-1:0] PMC_OFS_MODE = 8'h1C;
   localparam int unsigned PMC_PWR_STOP_BIT = 1;
   localparam int unsigned PMC_OSC_DIV_LSB = 0;
   localparam int unsigned PMC_OSC_SUSPEND_BIT = 5;
   localparam int unsigned PMC_OSC_READY_BIT = 6;
   localparam int unsigned PMC_MCD_EN_BIT = 0;
   localparam int unsigned PMC_IRQ_PORT = 0;
   localparam int unsigned PMC_IRQ_CMP = 1;
   localparam int unsigned PMC_IRQ_OSCRDY = 2;
   localparam int unsigned PMC_MODE_STATE_LSB = 0;
   localparam int unsigned PMC_MODE_RSRC_LSB = 8;
   localparam int unsigned PMC_RSRC_EXT = 0;
   localparam int unsigned PMC_RSRC_INT = 1;
   localparam int unsigned PMC_RSRC_MCD = 2;
   localparam logic [PMC_DIV_W-1:0] PMC_DIV_RESET = 3'h7;
   localparam logic PMC_MCD_EN_RESET = 1'b0;
   localparam logic [PMC_IRQ_W-1:0] PMC_IMASK_RESET = 3'h0;
   localparam logic [15:0] PMC_RESET_VECTOR = 16'h0000;
   localparam logic [PMC_DATA_W-1:0] PMC_ZERO_WORD = 32'h0000_0000;

   typedef enum logic [2:0] {
      PMC_ST_RESET = 3'h0,
      PMC_ST_RUN = 3'h1,
      PMC_ST_SUSPEND = 3'h3,
      PMC_ST_WAKE = 3'h2,
      PMC_ST_STOP = 3'h6
   } pmc_state_e;

   typedef struct packed {
      logic [3:0] portMatch;
      logic cmp0En;
      logic cmp0Out;
   } pmc_wake_s;

   typedef struct packed {
      logic oscRun;
      logic sysClkEn;
      logic cpuClkEn;
      logic periphClkEn;
      logic portMatchEn;
   } pmc_clk_s;
endpackage

// ===== hw/pmc_clk_div.sv
// Power-of-two post-divider giving the system clock enable
`timescale 1ns/1ps
module pmc_clk_div
   import pmc_pkg::*;
#(
   parameter int unsigned DIV_W = PMC_DIV_W,
   parameter int unsigned PRE_W = PMC_PRE_W
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic run,
   input wire logic [DIV_W-1:0] divSel,
   output logic tick
);
   logic [PRE_W-1:0] cnt_q;
   logic [PRE_W-1:0] mask;
   logic tick_q;

   // Select n gives a period of 2**n cycles
   always_comb begin
      mask = PRE_W'((1 << divSel) - 1);
   end

   always_ff @(posedge clk) begin
      if (sys_rst || !run) begin
         cnt_q <= '0;
      end else if ((cnt_q & mask) == mask) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + PRE_W'(1);
      end
   end

   // Stopped oscillator gives no ticks at all
   always_ff @(posedge clk) begin
      if (sys_rst || !run) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= ((cnt_q & mask) == mask);
      end
   end

   assign tick = tick_q;
endmodule

// ===== tb/pmc_power_ctrl_asserts.sv
// Port-level checks for the power-mode and clock controller
`timescale 1ns/1ps
module pmc_power_ctrl_asserts
   import pmc_pkg::*;
#(
   parameter int unsigned MCD_TIMEOUT_CYCLES = PMC_MCD_CYCLES,
   parameter int unsigned RST_SEQ_CYCLES = PMC_RST_SEQ_CYCLES,
   parameter int unsigned OSC_START_CYCLES = PMC_OSC_START_CYCLES,
   parameter int unsigned TRIM_W = PMC_TRIM_W
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PMC_ADDR_W-1:0] paddr,
   input wire logic [PMC_DATA_W-1:0] pwdata,
   input wire logic [PMC_DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire pmc_wake_s wake,
   input wire logic extRst,
   input wire logic intRstReq,
   input wire logic [TRIM_W-1:0] factoryCoarse,
   input wire logic [TRIM_W-1:0] factoryFine,
   input wire pmc_clk_s clkCtl,
   input wire logic [TRIM_W-1:0] coarseTrim,
   input wire logic [TRIM_W-1:0] fineTrim,
   input wire logic coreRst,
   input wire logic [15:0] resetVector,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic runWr;
   logic stopped;
   logic mcdEn_q;
   logic [15:0] stopCnt_q;
   // Oscillator on and out of reset; the bench never writes during wake-up
   assign runWr = psel && penable && pwrite && !coreRst && clkCtl.oscRun;
   assign stopped = !clkCtl.oscRun && !clkCtl.portMatchEn && !coreRst;
   // Detector enable is not a port, so shadow it from bus writes
   always_ff @(posedge clk) begin
      if (sys_rst || coreRst) begin
         mcdEn_q <= 1'b0;
      end else if (runWr && paddr == PMC_OFS_MCD) begin
         mcdEn_q <= pwdata[PMC_MCD_EN_BIT];
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst || !stopped) begin
         stopCnt_q <= 16'h0000;
      end else begin
         stopCnt_q <= stopCnt_q + 16'h0001;
      end
   end
   stop_entry_a: assert property (runWr && paddr == PMC_OFS_PWR && pwdata[1]
      |-> ##3 (clkCtl == '0) [*4]) else $error("stop left clocks running");
   stop_hold_a: assert property (stopped && !extRst && !intRstReq
      |=> !clkCtl.oscRun || coreRst) else $error("stop ended without reset");
   ext_reset_a: assert property (extRst |-> ##[1:2] coreRst)
      else $error("external reset not taken");
   reset_vector_a: assert property ($fell(coreRst) |-> resetVector == PMC_RESET_VECTOR)
      else $error("start address not zero");
   mcd_limit_a: assert property (mcdEn_q && stopped
      |-> stopCnt_q < MCD_TIMEOUT_CYCLES + 4) else $error("detector did not reset");
   suspend_entry_a: assert property (runWr && paddr == PMC_OFS_OSC && pwdata[5]
      |-> ##3 clkCtl.portMatchEn && !clkCtl.oscRun) else $error("suspend not entered");
   suspend_gate_a: assert property (clkCtl.portMatchEn && !clkCtl.oscRun
      |-> !clkCtl.cpuClkEn && !clkCtl.periphClkEn && !clkCtl.sysClkEn)
      else $error("clock enable while suspended");
   wake_osc_a: assert property (clkCtl.portMatchEn && !clkCtl.oscRun && !coreRst
      && (|wake.portMatch || (wake.cmp0En && !wake.cmp0Out)) |-> ##[1:3] clkCtl.oscRun)
      else $error("wake did not restart oscillator");
   osc_first_a: assert property (clkCtl.cpuClkEn || clkCtl.periphClkEn
      |-> clkCtl.oscRun) else $error("core clock without oscillator");
   trim_load_a: assert property ($fell(coreRst)
      |-> coarseTrim == factoryCoarse && fineTrim == factoryFine) else $error("trim not loaded");
   osc_default_a: assert property ($fell(sys_rst) |-> ##[1:3] clkCtl.oscRun)
      else $error("oscillator off after reset");
   cover property (clkCtl.portMatchEn && |wake.portMatch);
   cover property (stopped ##1 coreRst);
   cover property ($rose(irq));
endmodule

bind pmc_power_ctrl pmc_power_ctrl_asserts #(.MCD_TIMEOUT_CYCLES(MCD_TIMEOUT_CYCLES),
   .RST_SEQ_CYCLES(RST_SEQ_CYCLES), .OSC_START_CYCLES(OSC_START_CYCLES), .TRIM_W(TRIM_W)) chk (
   .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .wake(wake), .extRst(extRst), .intRstReq(intRstReq), .factoryCoarse(factoryCoarse),
   .factoryFine(factoryFine), .clkCtl(clkCtl), .coarseTrim(coarseTrim), .fineTrim(fineTrim),
   .coreRst(coreRst), .resetVector(resetVector), .irq(irq));

// ===== tb/pmc_core_model.sv
// Core model issuing firmware register accesses over APB
`timescale 1ns/1ps
module pmc_core_model
   import pmc_pkg::*;
(
   input wire logic clk,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [PMC_DATA_W-1:0] prdata,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [PMC_ADDR_W-1:0] paddr,
   output logic [PMC_DATA_W-1:0] pwdata
);
   logic zeroTc;
   logic lastErr;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      zeroTc = 1'b0;
      lastErr = 1'b0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // No cycle count assumed; the bench watchdog ends a hung wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines must not look like held data
      paddr <= ~a;
      pwdata <= ~d;
   endtask
   // Reference setting lives outside this block; only the order is modelled
   task automatic prep();
      zeroTc = 1'b1;
   endtask
endmodule

// ===== tb/power_mode_clock_control_test.sv
// Self-checking bench for the power-mode and clock controller
`timescale 1ns/1ps
`define CHK(g, e) chk(32'(g), 32'(e))
module power_mode_clock_control_test
   import pmc_pkg::*;
;
   localparam int MCD_N = 20;
   logic clk = 1'b0;
   logic sysRst = 1'b1;
   logic extRst = 1'b0;
   logic intRstReq = 1'b0;
   pmc_wake_s wake = '0;
   logic [7:0] facC, facF, paddr, coarseTrim, fineTrim, c;
   logic psel, penable, pwrite, pready, pslverr, coreRst, irq;
   logic [31:0] prdata, pwdata, r;
   logic [15:0] resetVector;
   pmc_clk_s clkCtl;
   int fail_count = 0;
   int samples_checked = 0;
   int seed = 32'h2f51_44ae;
   int regm [int];
   always #4 clk = ~clk;
   pmc_power_ctrl #(.MCD_TIMEOUT_CYCLES(MCD_N), .RST_SEQ_CYCLES(4), .OSC_START_CYCLES(3)) uut (
      .clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .wake(wake), .extRst(extRst), .intRstReq(intRstReq), .factoryCoarse(facC),
      .factoryFine(facF), .clkCtl(clkCtl), .coarseTrim(coarseTrim), .fineTrim(fineTrim),
      .coreRst(coreRst), .resetVector(resetVector), .irq(irq));
   pmc_core_model core (.clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic tdone(input string s);
      $display("test %s finished", s);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      core.xfer(1'b1, a, d, r);
      if (regm.exists(a)) begin
         regm[a] = d & (a == PMC_OFS_OSC || a == PMC_OFS_IMASK ? 7 : a == PMC_OFS_MCD ? 1 : 255);
      end
   endtask
   task automatic rd(input logic [7:0] a);
      core.xfer(1'b0, a, 32'h0000_0000, r);
   endtask
   task automatic rdc(input logic [7:0] a);
      rd(a);
      `CHK(r, regm[a] | (32'(a == PMC_OFS_OSC) << PMC_OSC_READY_BIT));
   endtask
   // Reset model: every reset reloads defaults and factory trim
   task automatic waitRun();
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (coreRst !== 1'b0 && n < 400);
      `CHK(coreRst, 1'b0);
      regm[PMC_OFS_OSC] = 7;
      regm[PMC_OFS_COARSE] = facC;
      regm[PMC_OFS_FINE] = facF;
      regm[PMC_OFS_MCD] = 0;
      regm[PMC_OFS_IMASK] = 0;
   endtask
   task automatic gap(output int g);
      int n;
      n = 0;
      do @(negedge clk); while (clkCtl.sysClkEn !== 1'b1 && n++ < 300);
      g = 0;
      do begin
         @(negedge clk);
         g++;
      end while (clkCtl.sysClkEn !== 1'b1 && g < 300);
   endtask
   initial begin
      #(8 * 40000);
      fail_count++;
      end_of_test();
   end
   initial begin
      int g;
      int k;
      facC = 8'($random(seed));
      facF = 8'($random(seed));
      repeat (10) @(posedge clk);
      sysRst <= 1'b0;
      waitRun();
      `CHK(resetVector, 16'h0000);
      `CHK(clkCtl.oscRun, 1'b1);
      rdc(PMC_OFS_OSC);
      rdc(PMC_OFS_FINE);
      gap(g);
      `CHK(g, 8'h80);
      tdone("reset");
      for (k = 0; k < 8; k++) begin
         wr(PMC_OFS_OSC, k);
         gap(g);
         gap(g);
         `CHK(g, 1 << k);
      end
      tdone("divider");
      c = 8'($random(seed));
      wr(PMC_OFS_COARSE, c);
      wr(PMC_OFS_FINE, ~c);
      rdc(PMC_OFS_COARSE);
      `CHK({coarseTrim, fineTrim}, {c, ~c});
      rd(8'h20);
      `CHK({core.lastErr, r[7:0]}, 9'h100);
      tdone("trim");
      wr(PMC_OFS_IMASK, 7);
      for (k = 0; k < 5; k++) begin
         c = 8'($random(seed));
         wr(PMC_OFS_FINE, c);
         if (k == 4) wr(PMC_OFS_IMASK, 0);
         core.prep();
         wr(PMC_OFS_OSC, 32'h20 | k);
         repeat (4) @(negedge clk);
         `CHK({clkCtl.oscRun, clkCtl.portMatchEn}, 2'b01);
         @(posedge clk);
         if (k == 4) begin
            wake.cmp0En <= 1'b1;
            wake.cmp0Out <= 1'b1;
            repeat (5) @(negedge clk);
            `CHK(clkCtl.oscRun, 1'b0);
            @(posedge clk);
            wake.cmp0Out <= 1'b0;
         end else begin
            wake.portMatch <= 4'(1 << k);
         end
         repeat (2) @(posedge clk);
         wake <= '0;
         g = 0;
         do begin
            rd(PMC_OFS_MODE);
            g++;
         end while (r[2:0] !== 3'h1 && g < 40);
         @(negedge clk);
         `CHK(irq, k < 4);
         rd(PMC_OFS_ISTAT);
         `CHK(r, (k < 4 ? 1 : 2) | 4);
         rd(PMC_OFS_ISTAT);
         `CHK(r, 0);
         @(negedge clk);
         `CHK(irq, 1'b0);
         rdc(PMC_OFS_FINE);
         rdc(PMC_OFS_OSC);
      end
      tdone("suspend");
      for (k = 0; k < 3; k++) begin
         if (k == 2) wr(PMC_OFS_MCD, 1);
         if (k != 1) begin
            wr(PMC_OFS_PWR, 2);
            repeat (3) @(negedge clk);
            `CHK(clkCtl, 5'h00);
         end
         if (k == 2) begin
            g = 0;
            do begin
               @(negedge clk);
               g++;
            end while (coreRst !== 1'b1 && g < 100);
            `CHK(g > MCD_N - 6 && g < MCD_N + 3, 1'b1);
         end else begin
            if (k == 0) begin
               @(posedge clk);
               wake.portMatch <= 4'hf;
               repeat (3) @(posedge clk);
               wake <= '0;
               rd(PMC_OFS_MODE);
               `CHK(r[2:0], 3'h6);
            end
            @(posedge clk);
            extRst <= (k == 0);
            intRstReq <= (k == 1);
            repeat (2) @(posedge clk);
            extRst <= 1'b0;
            intRstReq <= 1'b0;
            repeat (2) @(posedge clk);
         end
         waitRun();
         rd(PMC_OFS_MODE);
         `CHK(r[PMC_MODE_RSRC_LSB + k], 1'b1);
         `CHK(resetVector, 16'h0000);
         rdc(PMC_OFS_OSC);
         rdc(PMC_OFS_MCD);
      end
      tdone("reset sources");
      end_of_test();
   end
endmodule
